// ==== common/asuc_pkg.sv ====
// constants, register map and state types for the async serial unit core
package asuc_pkg;
    // register byte offsets
    localparam logic [7:0] ASUC_DATA_OFS = 8'h00;
    localparam logic [7:0] ASUC_RSR_OFS = 8'h04;
    localparam logic [7:0] ASUC_FLAG_OFS = 8'h18;
    localparam logic [7:0] ASUC_IBRD_OFS = 8'h24;
    localparam logic [7:0] ASUC_FBRD_OFS = 8'h28;
    localparam logic [7:0] ASUC_LCRH_OFS = 8'h2c;
    localparam logic [7:0] ASUC_CTL_OFS = 8'h30;
    localparam logic [7:0] ASUC_PINSEL_OFS = 8'h34;
    // line control fields
    localparam int ASUC_LC_BRK = 0;
    localparam int ASUC_LC_PEN = 1;
    localparam int ASUC_LC_EPS = 2;
    localparam int ASUC_LC_STP2 = 3;
    localparam int ASUC_LC_FEN = 4;
    localparam int ASUC_LC_WLEN_LO = 5;
    localparam int ASUC_LC_WLEN_HI = 6;
    localparam int ASUC_LC_SPS = 7;
    // serial control fields
    localparam int ASUC_CT_EN = 0;
    localparam int ASUC_CT_IR = 1;
    localparam int ASUC_CT_TXE = 8;
    localparam int ASUC_CT_RXE = 9;
    // flag register fields
    localparam int ASUC_FL_BUSY = 3;
    localparam int ASUC_FL_RXFE = 4;
    localparam int ASUC_FL_TXFF = 5;
    localparam int ASUC_FL_RXFF = 6;
    localparam int ASUC_FL_TXFE = 7;
    // reset values
    localparam logic [15:0] ASUC_CTL_RST = 16'h0300;
    localparam logic [7:0] ASUC_LCRH_RST = 8'h00;
    // data entry: 8 data bits and four error flags
    localparam int ASUC_DW = 8;
    localparam int ASUC_RXW = 12;
    localparam int ASUC_FIFO_DEPTH = 16;
    localparam logic [4:0] ASUC_FIFO_FULL = 5'h10;
    // divisor arithmetic in 1/64 units
    localparam logic [22:0] ASUC_FRAC_ONE = 23'h000040;
    // oversampling positions
    localparam logic [3:0] ASUC_SUB_LAST = 4'hf;
    localparam logic [3:0] ASUC_START_CHK = 4'h7;
    localparam logic [3:0] ASUC_IR_PULSE = 4'h3;
    localparam logic [2:0] ASUC_MIN_LAST = 3'h4;
    typedef enum logic [2:0] {ASUC_S_IDLE, ASUC_S_START, ASUC_S_DATA, ASUC_S_PAR, ASUC_S_STOP}
        asuc_state_t;
endpackage

// ==== logic/asuc_fifo.sv ====
// character queue with a one-entry holding mode
`timescale 1ns/1ps
module asuc_fifo #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // mode
    input wire logic one_deep,
    // fill side
    input wire logic push,
    input wire logic [W-1:0] push_data,
    // drain side
    input wire logic pop,
    output logic [W-1:0] head,
    // status
    output logic full,
    output logic empty
);
    import asuc_pkg::*;
    logic [W-1:0] mem [ASUC_FIFO_DEPTH];
    logic [3:0] wptr;
    logic [3:0] rptr;
    logic [4:0] count;
    logic do_push;
    logic do_pop;

    assign empty = (count == 5'h00);
    assign full = one_deep ? !empty : (count == ASUC_FIFO_FULL);
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign head = mem[rptr];

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wptr] <= push_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wptr <= 4'h0;
            rptr <= 4'h0;
            count <= 5'h00;
        end else begin
            if (do_push) begin
                wptr <= wptr + 4'h1;
            end
            if (do_pop) begin
                rptr <= rptr + 4'h1;
            end
            if (do_push && !do_pop) begin
                count <= count + 5'h01;
            end else if (do_pop && !do_push) begin
                count <= count - 5'h01;
            end
        end
    end
endmodule

// ==== logic/asuc_core.sv ====
// async serial transmitter/receiver with fractional baud generator
`timescale 1ns/1ps
// Notes on behaviour
// - transmit and receive enable bits are set after reset
// - clearing unit enable lets the character in flight finish first
// - send start, data lsb first, optional parity, then stop bits
// - each received character carries overrun, parity, framing and break flags
// - divisor is a 16-bit integer plus 6-bit fraction setting bit period
// - divisor equals system clock over sixteen times baud rate
// - oversample tick at 16x baud; divide by 16 for transmit bits
// - divisors and line settings load together only on line-control write
// - separate 16-entry queues; receive entries add four status bits
// - enabled transmitter sends queued characters back to back until empty
// - busy while queue non-empty or stop bits still leaving, even disabled
// - falling edge starts receive; start accepted if low on eighth tick
// - data bits sampled every sixteenth tick for programmed length
// - parity checked after data when enabled, per line settings
// - stop bit must be high else framing error; store character
// - infrared mode modulates transmit and receive pins
// - unit 0 pins come up as serial function, others general purpose
// - queues hold one entry after reset; fifo enable gives sixteen
// - data read gives 12 bits with flags; write queues eight bits
module asuc_core
    import asuc_pkg::*;
#(
    parameter int UNIT_INDEX = 0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // serial pins
    input wire logic serial_receive_pin,
    output logic serial_transmit_pin,
    output logic serial_transmit_oe,
    // status
    output logic uart_busy
);
    logic [15:0] integer_divisor_reg;
    logic [5:0] fraction_divisor_reg;
    logic [15:0] serial_control_reg;
    logic alternate_function_bit;
    logic [15:0] work_int;
    logic [5:0] work_frac;
    logic [7:0] line_control_reg;
    logic [3:0] rx_status;
    logic [22:0] baud_acc;
    logic [22:0] baud_divisor;
    logic oversample_tick;
    logic unit_enable_bit;
    logic transmit_enable_bit;
    logic receive_enable_bit;
    logic ir_mode;
    logic [2:0] last_idx;
    logic wr_hit;
    logic rd_hit;
    // transmit side
    asuc_state_t tx_state;
    logic [3:0] tx_sub;
    logic [2:0] tx_idx;
    logic [7:0] tx_shift;
    logic tx_par;
    logic tx_stop2;
    logic tx_level;
    logic tx_pop;
    logic tx_full;
    logic tx_empty;
    logic [7:0] tx_head;
    // receive side
    logic rx_sync1;
    logic rx_sync2;
    logic [3:0] ir_hold;
    logic rx_line;
    logic rx_prev;
    asuc_state_t rx_state;
    logic [3:0] rx_sub;
    logic [2:0] rx_idx;
    logic [7:0] rx_shift;
    logic rx_pe;
    logic rx_zero;
    logic rx_exp;
    logic rx_push;
    logic [11:0] rx_entry;
    logic rx_pop;
    logic rx_full;
    logic rx_empty;
    logic [11:0] rx_head;
    logic ovr_pend;
    logic rx_done;

    assign unit_enable_bit = serial_control_reg[ASUC_CT_EN];
    assign ir_mode = serial_control_reg[ASUC_CT_IR];
    assign transmit_enable_bit = serial_control_reg[ASUC_CT_TXE];
    assign receive_enable_bit = serial_control_reg[ASUC_CT_RXE];
    assign last_idx = ASUC_MIN_LAST + {1'b0, line_control_reg[ASUC_LC_WLEN_HI:ASUC_LC_WLEN_LO]};
    assign wr_hit = reg_wr && (reg_addr == ASUC_DATA_OFS);
    assign rd_hit = reg_rd && (reg_addr == ASUC_DATA_OFS);
    assign rx_pop = rd_hit;

    // register writes; a line-control write commits the divisors too
    always_ff @(posedge mclk) begin
        if (rst) begin
            integer_divisor_reg <= 16'h0000;
            fraction_divisor_reg <= 6'h00;
            serial_control_reg <= ASUC_CTL_RST;
            alternate_function_bit <= (UNIT_INDEX == 0);
            work_int <= 16'h0000;
            work_frac <= 6'h00;
            line_control_reg <= ASUC_LCRH_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                ASUC_IBRD_OFS: integer_divisor_reg <= reg_wdata[15:0];
                ASUC_FBRD_OFS: fraction_divisor_reg <= reg_wdata[5:0];
                ASUC_LCRH_OFS: begin
                    line_control_reg <= reg_wdata[7:0];
                    work_int <= integer_divisor_reg;
                    work_frac <= fraction_divisor_reg;
                end
                ASUC_CTL_OFS: serial_control_reg <= reg_wdata[15:0];
                ASUC_PINSEL_OFS: alternate_function_bit <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    // read data stands in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                ASUC_DATA_OFS: reg_rdata <= {20'h00000, rx_head};
                ASUC_RSR_OFS: reg_rdata <= {28'h0000000, rx_status};
                ASUC_FLAG_OFS: begin
                    reg_rdata <= 32'h00000000;
                    reg_rdata[ASUC_FL_BUSY] <= uart_busy;
                    reg_rdata[ASUC_FL_RXFE] <= rx_empty;
                    reg_rdata[ASUC_FL_TXFF] <= tx_full;
                    reg_rdata[ASUC_FL_RXFF] <= rx_full;
                    reg_rdata[ASUC_FL_TXFE] <= tx_empty;
                end
                ASUC_IBRD_OFS: reg_rdata <= {16'h0000, integer_divisor_reg};
                ASUC_FBRD_OFS: reg_rdata <= {26'h0000000, fraction_divisor_reg};
                ASUC_LCRH_OFS: reg_rdata <= {24'h000000, line_control_reg};
                ASUC_CTL_OFS: reg_rdata <= {16'h0000, serial_control_reg};
                ASUC_PINSEL_OFS: reg_rdata <= {31'h00000000, alternate_function_bit};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // error flags of the last character read; sticky overrun; write clears
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_status <= 4'h0;
        end else if (rd_hit && !rx_empty) begin
            rx_status <= {rx_status[3] | rx_head[11] | (rx_done && rx_full), rx_head[10:8]};
        end else if (reg_wr && (reg_addr == ASUC_RSR_OFS)) begin
            rx_status <= {rx_done && rx_full, 3'h0};
        end else if (rx_done && rx_full) begin
            rx_status[3] <= 1'b1;
        end
    end

    // fractional divider: add one each clock in 1/64 units, tick on wrap
    assign baud_divisor = {1'b0, work_int, work_frac};
    always_ff @(posedge mclk) begin
        if (rst) begin
            baud_acc <= 23'h000000;
            oversample_tick <= 1'b0;
        end else if (baud_divisor < ASUC_FRAC_ONE) begin
            baud_acc <= 23'h000000;
            oversample_tick <= 1'b0;
        end else if (baud_acc + ASUC_FRAC_ONE >= baud_divisor) begin
            baud_acc <= baud_acc + ASUC_FRAC_ONE - baud_divisor;
            oversample_tick <= 1'b1;
        end else begin
            baud_acc <= baud_acc + ASUC_FRAC_ONE;
            oversample_tick <= 1'b0;
        end
    end

    asuc_fifo #(
        .W(ASUC_DW)
    ) u_tx_fifo (
        .mclk(mclk),
        .rst(rst),
        .one_deep(!line_control_reg[ASUC_LC_FEN]),
        .push(wr_hit),
        .push_data(reg_wdata[7:0]),
        .pop(tx_pop),
        .head(tx_head),
        .full(tx_full),
        .empty(tx_empty)
    );

    asuc_fifo #(
        .W(ASUC_RXW)
    ) u_rx_fifo (
        .mclk(mclk),
        .rst(rst),
        .one_deep(!line_control_reg[ASUC_LC_FEN]),
        .push(rx_push),
        .push_data(rx_entry),
        .pop(rx_pop),
        .head(rx_head),
        .full(rx_full),
        .empty(rx_empty)
    );

    // transmitter: a new character starts only while enabled
    assign tx_pop = (tx_state == ASUC_S_IDLE) && unit_enable_bit && transmit_enable_bit
        && !tx_empty;
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_state <= ASUC_S_IDLE;
            tx_sub <= 4'h0;
            tx_idx <= 3'h0;
            tx_shift <= 8'h00;
            tx_par <= 1'b1;
            tx_stop2 <= 1'b0;
        end else if (tx_pop) begin
            tx_state <= ASUC_S_START;
            tx_sub <= 4'h0;
            tx_idx <= 3'h0;
            tx_shift <= tx_head;
            tx_stop2 <= 1'b0;
            if (line_control_reg[ASUC_LC_SPS]) begin
                tx_par <= !line_control_reg[ASUC_LC_EPS];
            end else begin
                tx_par <= (^(tx_head & ~(8'hff << ({1'b0, last_idx} + 4'h1))))
                    ^ !line_control_reg[ASUC_LC_EPS];
            end
        end else if (oversample_tick && tx_state != ASUC_S_IDLE) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == ASUC_SUB_LAST) begin
                case (tx_state)
                    ASUC_S_START: tx_state <= ASUC_S_DATA;
                    ASUC_S_DATA: begin
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_idx <= tx_idx + 3'h1;
                        if (tx_idx == last_idx) begin
                            tx_state <= line_control_reg[ASUC_LC_PEN] ? ASUC_S_PAR
                                : ASUC_S_STOP;
                        end
                    end
                    ASUC_S_PAR: tx_state <= ASUC_S_STOP;
                    ASUC_S_STOP: begin
                        if (line_control_reg[ASUC_LC_STP2] && !tx_stop2) begin
                            tx_stop2 <= 1'b1;
                        end else begin
                            tx_state <= ASUC_S_IDLE;
                        end
                    end
                    default: tx_state <= ASUC_S_IDLE;
                endcase
            end
        end
    end

    always_comb begin
        case (tx_state)
            ASUC_S_START: tx_level = 1'b0;
            ASUC_S_DATA: tx_level = tx_shift[0];
            ASUC_S_PAR: tx_level = tx_par;
            default: tx_level = 1'b1;
        endcase
    end

    // pin driver: plain level, break, or a short high pulse per zero bit
    always_ff @(posedge mclk) begin
        if (rst) begin
            serial_transmit_pin <= 1'b0;
            serial_transmit_oe <= (UNIT_INDEX == 0);
            uart_busy <= 1'b0;
        end else begin
            serial_transmit_oe <= alternate_function_bit;
            uart_busy <= !tx_empty || (tx_state != ASUC_S_IDLE) || tx_pop;
            if (!alternate_function_bit) begin
                serial_transmit_pin <= 1'b0;
            end else if (ir_mode) begin
                serial_transmit_pin <= !tx_level && (tx_sub < ASUC_IR_PULSE);
            end else begin
                serial_transmit_pin <= tx_level && !line_control_reg[ASUC_LC_BRK];
            end
        end
    end

    // receive pin synchroniser and infrared pulse stretcher
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
            ir_hold <= 4'h0;
            rx_prev <= 1'b1;
        end else begin
            rx_sync1 <= serial_receive_pin;
            rx_sync2 <= rx_sync1;
            rx_prev <= rx_line;
            if (!rx_sync2) begin
                ir_hold <= ASUC_SUB_LAST;
            end else if (oversample_tick && ir_hold != 4'h0) begin
                ir_hold <= ir_hold - 4'h1;
            end
        end
    end

    assign rx_line = !alternate_function_bit ? 1'b1
        : ir_mode ? (rx_sync2 && ir_hold == 4'h0) : rx_sync2;
    assign rx_exp = line_control_reg[ASUC_LC_SPS] ? !line_control_reg[ASUC_LC_EPS]
        : (^rx_shift) ^ !line_control_reg[ASUC_LC_EPS];
    assign rx_done = oversample_tick && (rx_state == ASUC_S_STOP) && (rx_sub == ASUC_SUB_LAST);

    // receiver
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_state <= ASUC_S_IDLE;
            rx_sub <= 4'h0;
            rx_idx <= 3'h0;
            rx_shift <= 8'h00;
            rx_pe <= 1'b0;
            rx_zero <= 1'b0;
            rx_push <= 1'b0;
            rx_entry <= 12'h000;
        end else begin
            rx_push <= 1'b0;
            case (rx_state)
                ASUC_S_IDLE: begin
                    if (unit_enable_bit && receive_enable_bit && rx_prev && !rx_line) begin
                        rx_state <= ASUC_S_START;
                        rx_sub <= 4'h0;
                        rx_idx <= 3'h0;
                        rx_shift <= 8'h00;
                        rx_pe <= 1'b0;
                        rx_zero <= 1'b1;
                    end
                end
                ASUC_S_START: begin
                    if (oversample_tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == ASUC_START_CHK) begin
                            rx_sub <= 4'h0;
                            rx_state <= rx_line ? ASUC_S_IDLE : ASUC_S_DATA;
                        end
                    end
                end
                ASUC_S_DATA: begin
                    if (oversample_tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == ASUC_SUB_LAST) begin
                            rx_shift[rx_idx] <= rx_line;
                            rx_zero <= rx_zero && !rx_line;
                            rx_idx <= rx_idx + 3'h1;
                            if (rx_idx == last_idx) begin
                                rx_state <= line_control_reg[ASUC_LC_PEN] ? ASUC_S_PAR
                                    : ASUC_S_STOP;
                            end
                        end
                    end
                end
                ASUC_S_PAR: begin
                    if (oversample_tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == ASUC_SUB_LAST) begin
                            rx_pe <= (rx_line != rx_exp);
                            rx_zero <= rx_zero && !rx_line;
                            rx_state <= ASUC_S_STOP;
                        end
                    end
                end
                ASUC_S_STOP: begin
                    if (oversample_tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == ASUC_SUB_LAST) begin
                            rx_state <= ASUC_S_IDLE;
                            rx_push <= 1'b1;
                            // overrun, break, parity, framing, data
                            rx_entry <= {ovr_pend, rx_zero && !rx_line, rx_pe, !rx_line,
                                rx_shift};
                        end
                    end
                end
                default: rx_state <= ASUC_S_IDLE;
            endcase
        end
    end

    // a character lost to a full queue flags the next one stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            ovr_pend <= 1'b0;
        end else if (rx_done && rx_full) begin
            ovr_pend <= 1'b1;
        end else if (rx_done) begin
            ovr_pend <= 1'b0;
        end
    end
endmodule

// ==== bench/asuc_core_monitor.sv ====
// concurrent checks on the async serial unit core ports
`timescale 1ns/1ps
module asuc_core_monitor
    import asuc_pkg::*;
#(
    parameter int UNIT_INDEX = 0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // pins and status
    input wire logic serial_receive_pin,
    input wire logic serial_transmit_pin,
    input wire logic serial_transmit_oe,
    input wire logic uart_busy
);
    logic [15:0] ctl;
    logic brk, sel, plain;
    logic [21:0] div_wr, div_c;
    logic [11:0] low_run;
    // pin owned, no infrared, no forced break
    assign plain = serial_transmit_oe && !ctl[ASUC_CT_IR] && !brk;
    // written settings; the divisor commits on a line-control write
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl <= ASUC_CTL_RST;
            brk <= 1'b0;
            sel <= (UNIT_INDEX == 0);
            div_wr <= 22'h000000;
            div_c <= 22'h000000;
        end else if (reg_wr) begin
            if (reg_addr == ASUC_CTL_OFS) ctl <= reg_wdata[15:0];
            if (reg_addr == ASUC_PINSEL_OFS) sel <= reg_wdata[0];
            if (reg_addr == ASUC_IBRD_OFS) div_wr[21:6] <= reg_wdata[15:0];
            if (reg_addr == ASUC_FBRD_OFS) div_wr[5:0] <= reg_wdata[5:0];
            if (reg_addr == ASUC_LCRH_OFS) brk <= reg_wdata[ASUC_LC_BRK];
            if (reg_addr == ASUC_LCRH_OFS) div_c <= div_wr;
        end
    end
    // length of the current low stretch on the transmit pin
    always_ff @(posedge mclk) begin
        if (rst || serial_transmit_pin) low_run <= 12'h000;
        else low_run <= low_run + 12'h001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence data_wr_s;
        reg_wr && reg_addr == ASUC_DATA_OFS;
    endsequence
    chk_unmapped_zero: assert property (reg_rd && reg_addr > ASUC_PINSEL_OFS |=> reg_rdata == 0)
        else $error("unmapped read gave data");
    chk_ctl_readback: assert property (reg_rd && reg_addr == ASUC_CTL_OFS |=>
        (reg_rdata[15:0] & 16'h0303) == ($past(ctl) & 16'h0303)) else $error("control readback");
    chk_data_width: assert property (
        reg_rd && reg_addr == ASUC_DATA_OFS |=> reg_rdata[31:12] == 20'h00000)
        else $error("data read too wide");
    chk_busy_on_write: assert property (data_wr_s ##1 1'b1 |=> uart_busy)
        else $error("busy late after write");
    chk_busy_in_char: assert property (
        !serial_transmit_pin && plain && !$past(rst) |-> uart_busy) else $error("low pin idle");
    chk_bit_period: assert property (
        $rose(serial_transmit_pin) && plain && div_c == 22'h000040 && !$past(rst, 2)
        |-> low_run[3:0] == 4'h0) else $error("partial bit period");
    chk_busy_fall_idle: assert property (
        $fell(uart_busy) && plain |-> serial_transmit_pin) else $error("busy fell early");
    chk_oe_select: assert property (!$past(reg_wr) |-> serial_transmit_oe == sel)
        else $error("pin ownership");
endmodule

// ==== bench/asuc_remote_model.sv ====
// remote serial device: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
module asuc_remote_model #(
    parameter int BIT_CLKS = 16
) (
    // clock
    input wire logic mclk,
    // serial lines
    input wire logic line_in,
    output logic line_out
);
    logic [8:0] got_q [$];
    initial line_out = 1'b1;
    // start, eight data bits lsb first, one stop level
    task automatic send_char(input logic [7:0] d, input logic stop);
        logic [9:0] fr;
        fr = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= fr[i];
            repeat (BIT_CLKS) @(posedge mclk);
        end
        line_out <= 1'b1;
    endtask
    // low pulse too short to survive the mid-start check
    task automatic glitch();
        line_out <= 1'b0;
        repeat (4) @(posedge mclk);
        line_out <= 1'b1;
    endtask
    // samples mid-bit, keeps {stop, data}
    initial begin
        logic [8:0] sh;
        wait (line_in === 1'b1);
        forever begin
            @(negedge line_in);
            repeat (BIT_CLKS / 2) @(posedge mclk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_CLKS) @(posedge mclk);
                sh[i] = line_in;
            end
            got_q.push_back(sh);
        end
    end
endmodule

// ==== bench/asuc_core_tb_top.sv ====
// self-checking bench for the async serial unit core
`timescale 1ns/1ps
module asuc_core_tb_top
    import asuc_pkg::*;
;
    typedef struct packed {logic [7:0] d; logic stop; logic [11:0] e;} asuc_rx_row_t;
    // good, bad stop, break
    asuc_rx_row_t rows [3] = '{'{8'h3c, 1'b1, 12'h03c}, '{8'h81, 1'b0, 12'h181},
        '{8'h00, 1'b0, 12'h500}};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic rx_line, tx_line, tx_oe, busy;
    int err_count = 0;
    int tests_run = 0;
    always #12.5 mclk = ~mclk;
    asuc_core u_asuc_core (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_receive_pin(rx_line),
        .serial_transmit_pin(tx_line), .serial_transmit_oe(tx_oe), .uart_busy(busy));
    asuc_remote_model u_asuc_remote_model (.mclk(mclk), .line_in(tx_line), .line_out(rx_line));
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // write cycle followed by an idle cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        check(what, exp, reg_rdata);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rdchk(ASUC_CTL_OFS, 32'h300, "control");
        rdchk(ASUC_LCRH_OFS, 32'h0, "line control");
        rdchk(ASUC_FLAG_OFS, 32'h90, "flags");
        rdchk(8'h3c, 32'h0, "unmapped");
        check("pin owned", 32'h1, {31'h0, tx_oe});
        wr(ASUC_IBRD_OFS, 32'h1);
        wr(ASUC_FBRD_OFS, 32'h0);
        wr(ASUC_LCRH_OFS, 32'h70);
        wr(ASUC_IBRD_OFS, 32'h2);
        for (int i = 0; i < 17; i++) wr(ASUC_DATA_OFS, 32'h10 + 32'(i));
        rdchk(ASUC_FLAG_OFS, 32'h38, "flags full");
        wr(ASUC_CTL_OFS, 32'h301);
        repeat (40) @(posedge mclk);
        wr(ASUC_CTL_OFS, 32'h300);
        repeat (400) @(posedge mclk);
        check("chars", 32'h1, 32'(u_asuc_remote_model.got_q.size()));
        check("busy off", 32'h1, {31'h0, busy});
        wr(ASUC_CTL_OFS, 32'h301);
        for (int n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge mclk);
        check("chars", 32'h10, 32'(u_asuc_remote_model.got_q.size()));
        for (int i = 0; i < 16; i++) begin
            check("tx char", 32'h110 + 32'(i), 32'(u_asuc_remote_model.got_q[i]));
        end
        for (int i = 0; i < 3; i++) begin
            u_asuc_remote_model.send_char(rows[i].d, rows[i].stop);
            repeat (40) @(posedge mclk);
            rdchk(ASUC_DATA_OFS, {20'h0, rows[i].e}, "rx char");
        end
        rdchk(ASUC_RSR_OFS, 32'h5, "rx status");
        u_asuc_remote_model.glitch();
        repeat (200) @(posedge mclk);
        rdchk(ASUC_FLAG_OFS, 32'h90, "flags glitch");
        // seven data bits, odd parity; the model's eighth bit lands in the parity slot
        wr(ASUC_CTL_OFS, 32'h300);
        wr(ASUC_IBRD_OFS, 32'h1);
        wr(ASUC_LCRH_OFS, 32'h52);
        wr(ASUC_CTL_OFS, 32'h301);
        u_asuc_remote_model.send_char(8'h81, 1'b1);
        repeat (40) @(posedge mclk);
        rdchk(ASUC_DATA_OFS, 32'h201, "rx parity bad");
        u_asuc_remote_model.send_char(8'h83, 1'b1);
        repeat (40) @(posedge mclk);
        rdchk(ASUC_DATA_OFS, 32'h003, "rx parity good");
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        stop_test();
    end
endmodule
bind asuc_core asuc_core_monitor #(.UNIT_INDEX(UNIT_INDEX)) u_asuc_core_monitor (.mclk(mclk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_receive_pin(serial_receive_pin),
    .serial_transmit_pin(serial_transmit_pin), .serial_transmit_oe(serial_transmit_oe),
    .uart_busy(uart_busy));
